// ==== shared/seq_pkg.sv ====
// Purpose: constants and types for the start-up and sync supervisor
// Assumes: 100 MHz core clock
// Notes: command codes other than the status and option words are local
package seq_pkg;
   localparam int CLK_MHZ = 100;
   localparam int LOSS_US = 10;
   localparam int LOSS_CYC = LOSS_US * CLK_MHZ;
   localparam int CYC_PER_MS = 1000 * CLK_MHZ;
   localparam int RESTART_EDGES = 7;
   localparam int STRAP_READS = 4;
   localparam int PB_PULSES = 128;
   localparam int OV_DIV = 20;
   localparam int AVG_SHIFT = 3;
   localparam logic [7:0] CMD_STATUS = 8'h80;
   localparam logic [7:0] CMD_MISC = 8'hf0;
   localparam logic [7:0] CMD_TON_RISE = 8'h61;
   localparam logic [7:0] CMD_TOFF_FALL = 8'h65;
   localparam logic [7:0] CMD_IOUT_OFS = 8'h39;
   localparam int BIT_SYNC_FLT = 1;
   localparam int BIT_SS_INVALID = 3;
   localparam int MISC_SYNC_DIS = 0;
   localparam logic [15:0] MISC_RESET = 16'h0000;
   localparam logic [7:0] TON_DEFAULT = 8'h03;
   localparam logic [7:0] TON_MIN = 8'h01;
   localparam logic [7:0] TON_MAX = 8'h64;
   localparam logic [7:0] TOFF_MIN = 8'h01;
   localparam logic [3:0] STRAP_PULLUP = 4'hf;
   typedef struct packed
   {
      logic wr;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_t;
   typedef enum logic [2:0]
   {
      ST_OFF = 3'b000,
      ST_WAIT_CLK = 3'b001,
      ST_RAMP = 3'b010,
      ST_RUN = 3'b011,
      ST_STOP = 3'b100
   } seq_state_t;
endpackage

// ==== design/sync_fault_softstart_sequencer.sv ====
// Purpose: sync-loss supervision, soft-start/stop sequencing, current average
// Assumes: all inputs synchronous to clock; sw_cycle pulses once per switch period
// Notes: analog loop lives outside, overvoltage limit is derived here from vref_target; levels are plain codes
`timescale 1ns/1ps
module sync_fault_softstart_sequencer
   import seq_pkg::*;
#(
   parameter int LW = 12,
   parameter int STALL_CYC = 625
)
(
   input wire logic clock,
   input wire logic rst,
   input wire cmd_t cmd,
   input wire logic sync_in,
   input wire logic sync_expected,
   input wire logic clock_slave,
   input wire logic loop_slave,
   input wire logic on_request,
   input wire logic softstop_disable,
   input wire logic share_low_in,
   input wire logic local_fault,
   input wire logic [3:0] strap_code,
   input wire logic [7:0] stored_ton_ms,
   input wire logic [LW-1:0] fb_level,
   input wire logic [LW-1:0] vref_target,
   input wire logic sw_cycle,
   input wire logic ls_midpoint,
   input wire logic [LW-1:0] isense,
   output logic hs_en,
   output logic ls_en,
   output logic ls_complementary,
   output logic [7:0] ls_ramp_count,
   output logic share_pull_oe,
   output logic freq_slow,
   output logic [LW-1:0] ref_level,
   output logic ov_warn,
   output logic [7:0] vendor_status_flags,
   output logic [15:0] misc_option_config,
   output logic [7:0] ton_rise_ms,
   output logic [LW-1:0] read_iout
);

   function automatic logic [7:0] strap_ms(input logic [3:0] c);
      case (c)
         4'h0: strap_ms = 8'h03;
         4'h1: strap_ms = 8'h01;
         4'h2: strap_ms = 8'h02;
         4'h3: strap_ms = 8'h03;
         4'h4: strap_ms = 8'h05;
         4'h5: strap_ms = 8'h07;
         4'h6: strap_ms = 8'h0a;
         4'h7: strap_ms = 8'h1b;
         4'h8: strap_ms = 8'h34;
         default: strap_ms = TON_DEFAULT;
      endcase
   endfunction

   // cycles per reference step scale: ms * cycles-per-ms
   function automatic logic [31:0] span(input logic [7:0] ms);
      span = 32'(ms) * 32'(CYC_PER_MS);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // sync clock supervision
   logic sync_d_r, seen_r, fault_r, restart_r, slow_r;
   logic sync_d_nxt, seen_nxt, fault_nxt, restart_nxt, slow_nxt;
   logic [15:0] since_r, since_nxt;
   logic [2:0] edges_r, edges_nxt;
   logic edge_hit, missing, sync_dis;

   always_comb
   begin
      sync_dis = misc_option_config[MISC_SYNC_DIS];
      // slave follows falling edge, others rising
      edge_hit = loop_slave ? (sync_d_r & ~sync_in) : (~sync_d_r & sync_in);
      sync_d_nxt = sync_in;
      seen_nxt = seen_r | edge_hit;
      since_nxt = since_r;
      if (edge_hit)
         since_nxt = '0;
      else if (since_r < 16'(LOSS_CYC))
         since_nxt = since_r + 16'h0001;
      // never seen, or silent for the loss time
      missing = sync_expected & (~seen_r | since_r >= 16'(LOSS_CYC));
      // slave runs slow while the clock is stalled but not yet lost
      slow_nxt = clock_slave & sync_expected & seen_r & ~edge_hit
                 & since_r >= 16'(STALL_CYC) & since_r < 16'(LOSS_CYC);
      edges_nxt = edges_r;
      restart_nxt = 1'b0;
      fault_nxt = fault_r;
      if (missing & ~sync_dis)
      begin
         fault_nxt = 1'b1;
         edges_nxt = '0;
      end
      else if (fault_r & (sync_dis | ~sync_expected))
         fault_nxt = 1'b0;
      else if (fault_r & edge_hit)
      begin
         // count edges after return, then restart by itself
         if (edges_r == 3'(RESTART_EDGES - 1))
         begin
            fault_nxt = 1'b0;
            restart_nxt = 1'b1;
            edges_nxt = '0;
         end
         else
            edges_nxt = edges_r + 3'h1;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sync_d_r <= 1'b0;
         seen_r <= 1'b0;
         since_r <= '0;
         edges_r <= '0;
         fault_r <= 1'b0;
         restart_r <= 1'b0;
         slow_r <= 1'b0;
      end
      else
      begin
         sync_d_r <= sync_d_nxt;
         seen_r <= seen_nxt;
         since_r <= since_nxt;
         edges_r <= edges_nxt;
         fault_r <= fault_nxt;
         restart_r <= restart_nxt;
         slow_r <= slow_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // strap decode and command words
   logic [2:0] strap_cnt_r, strap_cnt_nxt;
   logic [3:0] strap_first_r, strap_first_nxt;
   logic strap_bad_r, strap_bad_nxt, ss_inv_r, ss_inv_nxt;
   logic [7:0] ton_r, ton_nxt, toff_r, toff_nxt;
   logic [15:0] misc_r, misc_nxt;
   logic [LW-1:0] ofs_r, ofs_nxt;

   always_comb
   begin
      strap_cnt_nxt = strap_cnt_r;
      strap_first_nxt = strap_first_r;
      strap_bad_nxt = strap_bad_r;
      ss_inv_nxt = ss_inv_r;
      ton_nxt = ton_r;
      toff_nxt = toff_r;
      misc_nxt = misc_r;
      ofs_nxt = ofs_r;
      if (strap_cnt_r < 3'(STRAP_READS))
      begin
         strap_cnt_nxt = strap_cnt_r + 3'h1;
         if (strap_cnt_r == '0)
            strap_first_nxt = strap_code;
         else if (strap_code != strap_first_r)
            strap_bad_nxt = 1'b1;
         if (strap_cnt_r == 3'(STRAP_READS - 1))
         begin
            // unresolved strap: default time, flag only
            if (strap_bad_nxt)
            begin
               ton_nxt = TON_DEFAULT;
               ss_inv_nxt = 1'b1;
            end
            else if (strap_first_r == STRAP_PULLUP)
               ton_nxt = stored_ton_ms;
            else
               ton_nxt = strap_ms(strap_first_r);
         end
      end
      else if (cmd.wr)
      begin
         case (cmd.code)
            CMD_TON_RISE:
            begin
               // write overrides strap, clamped to supported span
               if (cmd.data[7:0] < TON_MIN)
                  ton_nxt = TON_MIN;
               else if (cmd.data[7:0] > TON_MAX)
                  ton_nxt = TON_MAX;
               else
                  ton_nxt = cmd.data[7:0];
            end
            CMD_TOFF_FALL: toff_nxt = cmd.data[7:0];
            CMD_MISC: misc_nxt = cmd.data;
            CMD_IOUT_OFS: ofs_nxt = cmd.data[LW-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         strap_cnt_r <= '0;
         strap_first_r <= '0;
         strap_bad_r <= 1'b0;
         ss_inv_r <= 1'b0;
         ton_r <= TON_DEFAULT;
         toff_r <= '0;
         misc_r <= MISC_RESET;
         ofs_r <= '0;
      end
      else
      begin
         strap_cnt_r <= strap_cnt_nxt;
         strap_first_r <= strap_first_nxt;
         strap_bad_r <= strap_bad_nxt;
         ss_inv_r <= ss_inv_nxt;
         ton_r <= ton_nxt;
         toff_r <= toff_nxt;
         misc_r <= misc_nxt;
         ofs_r <= ofs_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // soft-start / soft-stop sequencer
   seq_state_t state_r, state_nxt;
   logic [31:0] acc_r, acc_nxt, per;
   logic [LW-1:0] ref_r, ref_nxt;
   logic sw_on_r, sw_on_nxt, hs_nxt, share_nxt, ov_nxt;
   logic [7:0] pb_r, pb_nxt, toff_eff;
   logic halt, ext_stop, step;
   logic [LW:0] ov_lim;

   always_comb
   begin
      halt = fault_r & ~misc_option_config[MISC_SYNC_DIS];
      ext_stop = share_low_in | local_fault;
      toff_eff = (toff_r == '0) ? TOFF_MIN : toff_r;
      per = span(state_r == ST_STOP ? toff_eff : ton_r);
      step = (acc_r + 32'(vref_target)) >= per;
      state_nxt = state_r;
      ref_nxt = ref_r;
      acc_nxt = step ? acc_r + 32'(vref_target) - per : acc_r + 32'(vref_target);
      sw_on_nxt = sw_on_r;
      pb_nxt = pb_r;
      case (state_r)
         ST_OFF, ST_WAIT_CLK:
         begin
            ref_nxt = '0;
            acc_nxt = '0;
            sw_on_nxt = 1'b0;
            pb_nxt = '0;
            if (~on_request)
               state_nxt = ST_OFF;
            else if (halt)
               state_nxt = ST_WAIT_CLK;
            else if (~ext_stop)
               state_nxt = ST_RAMP;
         end
         ST_RAMP, ST_RUN:
         begin
            if (state_r == ST_RAMP)
            begin
               if (step)
                  ref_nxt = ref_r + 1'b1;
               // switching waits for reference above pre-bias
               if (ref_r > fb_level)
                  sw_on_nxt = 1'b1;
               if (ref_r >= vref_target)
               begin
                  ref_nxt = vref_target;
                  sw_on_nxt = 1'b1;
                  state_nxt = ST_RUN;
               end
            end
            if (sw_on_r & sw_cycle & pb_r < 8'(PB_PULSES))
               pb_nxt = pb_r + 8'h01;
            if (~on_request)
               state_nxt = softstop_disable ? ST_OFF : ST_STOP;
         end
         ST_STOP:
         begin
            if (step & ref_r != '0)
               ref_nxt = ref_r - 1'b1;
            if (ref_r == '0)
               state_nxt = ST_OFF;
            if (on_request)
               state_nxt = ST_RAMP;
         end
         default: state_nxt = ST_OFF;
      endcase
      if (halt & state_nxt != ST_OFF)
         state_nxt = ST_WAIT_CLK;
      else if (ext_stop & state_nxt != ST_WAIT_CLK)
         state_nxt = ST_OFF;
      hs_nxt = sw_on_nxt & (state_nxt == ST_RAMP | state_nxt == ST_RUN | state_nxt == ST_STOP);
      share_nxt = local_fault | halt;
      ov_lim = {1'b0, vref_target} + (LW + 1)'(vref_target / LW'(OV_DIV));
      ov_nxt = {1'b0, fb_level} > ov_lim;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_OFF;
         acc_r <= '0;
         ref_r <= '0;
         sw_on_r <= 1'b0;
         pb_r <= '0;
         hs_en <= 1'b0;
         ls_en <= 1'b0;
         share_pull_oe <= 1'b0;
         ov_warn <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         ref_r <= ref_nxt;
         sw_on_r <= sw_on_nxt;
         pb_r <= pb_nxt;
         hs_en <= hs_nxt;
         ls_en <= hs_nxt;
         share_pull_oe <= share_nxt;
         ov_warn <= ov_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // current average and register views
   logic [LW-1:0] iavg_r, iavg_nxt, corr;
   logic [7:0] stat_nxt;
   logic signed [LW+1:0] diff;

   always_comb
   begin
      corr = (isense > ofs_r) ? isense - ofs_r : '0;
      diff = $signed({2'b00, corr}) - $signed({2'b00, iavg_r});
      iavg_nxt = iavg_r;
      // sample only mid low-side while driving
      if (ls_midpoint & ls_en)
         iavg_nxt = iavg_r + LW'(diff >>> AVG_SHIFT);
      stat_nxt = '0;
      // sync flag is a live level, no latch; strap flag holds until reset; no alert path
      stat_nxt[BIT_SYNC_FLT] = missing & ~misc_r[MISC_SYNC_DIS];
      stat_nxt[BIT_SS_INVALID] = ss_inv_r;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         iavg_r <= '0;
         read_iout <= '0;
         vendor_status_flags <= '0;
         misc_option_config <= MISC_RESET;
         ton_rise_ms <= TON_DEFAULT;
         freq_slow <= 1'b0;
         ref_level <= '0;
         ls_ramp_count <= '0;
         ls_complementary <= 1'b0;
      end
      else
      begin
         iavg_r <= iavg_nxt;
         read_iout <= iavg_nxt;
         vendor_status_flags <= stat_nxt;
         misc_option_config <= misc_r;
         ton_rise_ms <= ton_r;
         freq_slow <= slow_r;
         ref_level <= ref_r;
         ls_ramp_count <= pb_r;
         ls_complementary <= pb_r == 8'(PB_PULSES);
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_silent;
      sync_expected && seen_r && !sync_dis && since_r == 16'(LOSS_CYC - 1) && !edge_hit;
   endsequence

   loss_flag_a: assert property (s_silent |=> ##1 vendor_status_flags[BIT_SYNC_FLT])
      else $error("sync loss not flagged in time");
   halt_drive_a: assert property (halt |=> !hs_en)
      else $error("switching while clock missing");
   // own share pull lags the clear by one edge, so allow a second cycle
   restart_a: assert property (restart_r && on_request && state_r == ST_WAIT_CLK
      |-> ##[1:2] (state_r == ST_RAMP || ext_stop || halt))
      else $error("no restart after clock return");
   master_speed_a: assert property (!clock_slave |=> !slow_r)
      else $error("clock master slowed");
   prebias_a: assert property (state_r == ST_RAMP && !sw_on_r && ref_r <= fb_level
      && ref_r < vref_target |=> !hs_en)
      else $error("pulses during pre-bias");
   pb_done_a: assert property (ls_complementary |-> ls_ramp_count == 8'(PB_PULSES))
      else $error("complementary before 128 pulses");
   hard_off_a: assert property ((state_r == ST_RAMP || state_r == ST_RUN) && !on_request && softstop_disable
      |=> !hs_en && !ls_en)
      else $error("drivers not off at once");
   share_stop_a: assert property (share_low_in |=> !hs_en ##1 !hs_en || !share_low_in)
      else $error("switching with shared line low");
   dis_hide_a: assert property (misc_option_config[MISC_SYNC_DIS] && misc_r[MISC_SYNC_DIS]
      |=> !vendor_status_flags[BIT_SYNC_FLT])
      else $error("sync loss shown while disabled");
endmodule

// ==== dv/sync_partner.sv ====
// Purpose: stacked partner converter and external sync clock source
// Assumes: bench clock; sync changes land on the rising edge, non-blocking
// Notes: a stopped source holds its last level, as a lost clock does
`timescale 1ns/1ps
module sync_partner
(
   input wire logic clock,
   input wire logic run,
   input wire logic dut_pull,
   input wire logic own_fault,
   output logic sync_in,
   output logic share_low_in,
   output logic partner_switching
);
   logic [1:0] ph = 2'h0;
   logic sync_r = 1'b0;
   ////////////////////////////////////////////////////////////////
   // sync source: period of eight core cycles while running
   // rising edge so run, set at the falling edge, is sampled race-free
   always @(posedge clock)
      if (run)
      begin
         ph <= ph + 2'h1;
         if (ph == 2'h3)
            sync_r <= ~sync_r;
      end
   assign sync_in = sync_r;
   ////////////////////////////////////////////////////////////////
   // shared loop line: either party's pull beats the pull-up
   assign share_low_in = dut_pull | own_fault;
   assign partner_switching = !share_low_in;
endmodule

// ==== dv/sync_fault_softstart_sequencer_test.sv ====
// Purpose: self-checking bench for the sync and soft-start sequencer
// Assumes: partner model supplies sync clock and shared fault line
// Notes: stall gap shortened to 20 cycles; ramps use 1 ms rise time
`timescale 1ns/1ps
module sync_fault_softstart_sequencer_test import seq_pkg::*;;
   logic clock = 1'b0;
   logic rst = 1'b1;
   cmd_t cmd = '0;
   logic run = 0, sync_exp = 0, cslave = 0, on = 0, ssdis = 0, lslave = 0;
   logic pfault = 0, lfault = 0, sw = 0, mid = 0;
   logic [3:0] strap = 4'h0;
   logic [11:0] fb = 12'h000;
   logic [11:0] isense = 12'h000;
   logic sync_in, share_low, hs_en, ls_en, ls_cmp, pull_oe, slow, ovw;
   logic [7:0] cnt, status, ton;
   logic [15:0] misc;
   logic [11:0] ref_l, iout;
   int n_errors = 0;
   int samples_checked = 0;
   int n;
   always #5 clock = ~clock;
   sync_partner partner (.clock(clock), .run(run), .dut_pull(pull_oe), .own_fault(pfault),
      .sync_in(sync_in), .share_low_in(share_low), .partner_switching());
   sync_fault_softstart_sequencer #(.LW(12), .STALL_CYC(20)) DUT (.clock(clock), .rst(rst),
      .cmd(cmd), .sync_in(sync_in), .sync_expected(sync_exp), .clock_slave(cslave),
      .loop_slave(lslave), .on_request(on), .softstop_disable(ssdis), .share_low_in(share_low),
      .local_fault(lfault), .strap_code(strap), .stored_ton_ms(8'h09), .fb_level(fb),
      .vref_target(12'h400), .sw_cycle(sw), .ls_midpoint(mid), .isense(isense),
      .hs_en(hs_en), .ls_en(ls_en), .ls_complementary(ls_cmp), .ls_ramp_count(cnt),
      .share_pull_oe(pull_oe), .freq_slow(slow), .ref_level(ref_l), .ov_warn(ovw),
      .vendor_status_flags(status), .misc_option_config(misc), .ton_rise_ms(ton),
      .read_iout(iout));
   ////////////////////////////////////////////////////////////////
   task automatic results;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("BAD %0t got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask
   function automatic logic sel(input int k);
      case (k)
         0: return hs_en;
         2: return slow;
         3: return sync_in;
         default: return status[1];
      endcase
   endfunction
   // bounded wait; n keeps the cycles spent for timing checks
   task automatic waitc(input int k, input logic v, input int lim);
      n = 0;
      while (sel(k) !== v && n < lim)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= lim)
      begin
         $display("BAD %0t wait ran out", $time);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd = {1'b1, c, d};
      @(negedge clock);
      cmd.wr = 1'b0;
      cyc(2);
   endtask
   // strap is sampled just after release, so it is set before
   task automatic do_reset(input logic [3:0] s);
      strap = s;
      rst = 1'b1;
      cyc(16);
      rst = 1'b0;
      cyc(8);
   endtask
   task automatic pulse_sw;
      sw = 1'b1;
      @(negedge clock);
      sw = 1'b0;
      @(negedge clock);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_strap;
      logic [3:0] sc [10];
      logic [7:0] ex [10];
      sc = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
      ex = '{8'h03, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0a, 8'h1b, 8'h34, 8'h09};
      for (int i = 0; i < 10; i++)
      begin
         do_reset(sc[i]);
         chk(ton, ex[i]);
      end
      chk(status, 8'h00);
      chk(misc, MISC_RESET);
      // strap moves between the second and third read
      strap = 4'h2;
      rst = 1'b1;
      cyc(16);
      rst = 1'b0;
      cyc(2);
      strap = 4'h5;
      cyc(6);
      chk(ton, 8'h03);
      chk(status, 8'h08);
      do_reset(4'h3);
   endtask
   task automatic t_regs;
      wr(CMD_TON_RISE, 16'h0005);
      chk(ton, 8'h05);
      wr(CMD_TON_RISE, 16'h00c8);
      chk(ton, 8'h64);
      wr(CMD_TON_RISE, 16'h0000);
      chk(ton, 8'h01);
      wr(CMD_MISC, 16'ha5f0);
      chk(misc, 16'ha5f0);
      wr(8'h22, 16'h0001);
      wr(CMD_STATUS, 16'h00ff);
      chk(misc, 16'ha5f0);
      chk(status, 8'h00);
      do_reset(4'h1);
      chk(ton, 8'h01);
      chk(misc, MISC_RESET);
   endtask
   task automatic t_sync;
      sync_exp = 1;
      cslave = 1;
      on = 1;
      fb = 12'h005;
      cyc(1100);
      chk(hs_en, 0);
      chk(status[1], 1);
      run = 1;
      cyc(40);
      chk(hs_en, 0);
      chk(status[1], 0);
      waitc(0, 1, 3000);
      chk(ref_l > fb, 1);
      repeat (127) pulse_sw;
      chk(ls_cmp, 0);
      pulse_sw;
      cyc(2);
      chk(ls_cmp, 1);
      chk(cnt, 8'h80);
      isense = 12'h320;
      mid = 1;
      @(negedge clock);
      mid = 0;
      cyc(2);
      chk(iout, 12'h064);
      wr(CMD_IOUT_OFS, 16'h0020);
      mid = 1;
      @(negedge clock);
      mid = 0;
      cyc(2);
      chk(iout, 12'h0b7);
   endtask
   task automatic t_loss;
      // stop just after a rising sync edge
      waitc(3, 0, 20);
      waitc(3, 1, 20);
      run = 0;
      waitc(2, 1, 40);
      chk(16'(n), 16'h0017);
      chk(slow, 1);
      waitc(1, 1, 1100);
      chk(n >= 900, 1);
      cyc(2);
      chk(hs_en, 0);
      run = 1;
      waitc(1, 0, 100);
      waitc(0, 1, 3000);
      cslave = 0;
      run = 0;
      cyc(30);
      chk(slow, 0);
      run = 1;
      cyc(20);
      cslave = 1;
      wr(CMD_MISC, 16'h0001);
      run = 0;
      cyc(30);
      chk(slow, 1);
      cyc(1200);
      chk(slow, 0);
      chk(status[1], 0);
      chk(hs_en, 1);
      run = 1;
      wr(CMD_MISC, 16'h0000);
      // loop slave: the falling edge four cycles earlier is the last one
      lslave = 1;
      cyc(16);
      waitc(3, 0, 20);
      waitc(3, 1, 20);
      run = 0;
      waitc(2, 1, 40);
      chk(16'(n), 16'h0013);
      run = 1;
      cyc(16);
      lslave = 0;
   endtask
   task automatic t_fault;
      int r;
      lfault = 1;
      cyc(3);
      chk(pull_oe, 1);
      chk(hs_en, 0);
      lfault = 0;
      waitc(0, 1, 3000);
      pfault = 1;
      cyc(3);
      chk(hs_en, 0);
      pfault = 0;
      waitc(0, 1, 3000);
      fb = 12'h434;
      cyc(3);
      chk(ovw, 1);
      fb = 12'h433;
      cyc(3);
      chk(ovw, 0);
      // soft-stop with fall time 0: one reference step per 1 ms / 1024
      fb = 12'h005;
      wr(CMD_TOFF_FALL, 16'h0000);
      r = ref_l;
      on = 0;
      cyc(2);
      chk(hs_en, 1);
      waitc(0, 0, 2000);
      chk(n * 1024 >= (r - 2) * CYC_PER_MS, 1);
      chk(n * 1024 <= (r + 2) * CYC_PER_MS, 1);
      on = 1;
      waitc(0, 1, 3000);
      ssdis = 1;
      on = 0;
      cyc(2);
      chk({hs_en, ls_en}, 0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      t_strap;
      t_regs;
      t_sync;
      t_loss;
      t_fault;
      results;
   end
   // whole run needs some 8k cycles; 40k cuts a hang short
   initial
   begin
      #400000;
      $display("BAD %0t watchdog expired", $time);
      n_errors++;
      results;
   end
endmodule
